// file: rtl/tofacq_pkg.sv
package tofacq_pkg;

    // ****************************************
    // Register map (I2C byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_TIMING_CFG_A  = 8'h22;
    localparam logic [7:0] ADDR_TIMING_CFG_B  = 8'h25;
    localparam logic [7:0] ADDR_ILLUM_SELECT  = 8'h3c;
    localparam logic [7:0] ADDR_TEMP_FIRST    = 8'h60;
    localparam logic [7:0] ADDR_TEMP_LAST     = 8'h67;
    localparam logic [7:0] ADDR_INT_PRESCALER = 8'h85;
    localparam logic [7:0] ADDR_MEAS_MODE     = 8'h92;
    localparam logic [7:0] ADDR_SPECIAL_MODE  = 8'h94;
    localparam logic [7:0] ADDR_ROI_FIRST     = 8'h96;
    localparam logic [7:0] ADDR_ROI_LAST      = 8'h9b;
    localparam logic [7:0] ADDR_REPEAT_HI     = 8'ha0;
    localparam logic [7:0] ADDR_REPEAT_LO     = 8'ha1;
    localparam logic [7:0] ADDR_COUNT_HI      = 8'ha2;
    localparam logic [7:0] ADDR_COUNT_LO      = 8'ha3;
    localparam logic [7:0] ADDR_ACQ_TRIGGER   = 8'ha4;
    localparam logic [7:0] ADDR_EMULATION     = 8'ha6;

    // ****************************************
    // Reset values and codes
    // ****************************************
    localparam logic [7:0] RST_TIMING_CFG_A  = 8'h30;
    localparam logic [7:0] RST_TIMING_CFG_B  = 8'h35;
    localparam logic [7:0] RST_SPECIAL_MODE  = 8'h00;
    localparam logic [7:0] RST_ILLUM_SELECT  = 8'h26;
    localparam logic [7:0] RST_INT_PRESCALER = 8'h00;
    localparam logic [7:0] MODE_DIST4        = 8'h34;
    localparam logic [7:0] MODE_DIST2        = 8'h14;
    localparam logic [7:0] MODE_GRAY         = 8'hc4;
    localparam logic [7:0] MODE_DUAL_DIST4   = 8'h3c;
    localparam logic [7:0] MODE_DUAL_DIST2   = 8'h1c;
    localparam logic [7:0] MODE_DUAL_GRAY    = 8'hcc;
    localparam logic [7:0] SPECIAL_DUAL      = 8'h80;
    localparam logic [7:0] DUALPH_CFG_A      = 8'h34;
    localparam logic [7:0] DUALPH_CFG_B      = 8'h3e;
    localparam logic [7:0] TRIGGER_CODE      = 8'h01;
    localparam logic [7:0] ILLUM_AMBIENT     = 8'h26;
    localparam logic [7:0] ILLUM_DC          = 8'h16;
    localparam logic [7:0] ILLUM_MODULATED   = 8'h06;
    localparam logic [15:0] RST_REPEAT       = 16'h0001;
    localparam logic [15:0] RST_COUNT        = 16'h12bf;
    localparam logic [15:0] TEMP_DEFAULT     = 16'h2000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ        = 200;
    localparam int INT_TICK_MHZ   = 96;
    localparam int STRAP_SCAN_NS  = 1000;
    localparam int STRAP_CYCLES   = (STRAP_SCAN_NS * CLK_MHZ + 999) / 1000;
    localparam int EE_COPY_WORDS  = 128;
    localparam int SHUTTER_SYNC   = 2;

    typedef enum logic [2:0] {
        TOFACQ_ST_STRAP  = 3'b000,
        TOFACQ_ST_COPY   = 3'b001,
        TOFACQ_ST_READY  = 3'b011,
        TOFACQ_ST_INTEG  = 3'b010,
        TOFACQ_ST_CONV   = 3'b110,
        TOFACQ_ST_WAIT   = 3'b111
    } tofacq_state_t;

    typedef enum logic [1:0] {
        TOFACQ_LK_IDLE = 2'b00,
        TOFACQ_LK_ROW  = 2'b01,
        TOFACQ_LK_GAP  = 2'b11
    } tofacq_link_t;

endpackage

// file: rtl/tofacq_top.sv
`timescale 1ns/1ps
module tofacq_top
    import tofacq_pkg::*;
#(
    parameter int COLS          = 320,
    parameter int ROWS          = 240,
    parameter int EE_COPY_TIME  = EE_COPY_WORDS * 8,
    parameter int CONV_CYCLES   = 64
) (
    input  wire logic       clk,             // System clock, 200 MHz
    input  wire logic       reset,           // Synchronous reset, active high
    input  wire logic       pixel_clock,     // Link clock of the video port
    input  wire logic       shutter_pin,     // Shutter pulse, asynchronous
    input  wire logic       reg_wr,          // Register write strobe
    input  wire logic       reg_rd,          // Register read strobe
    input  wire logic [7:0] reg_addr,        // Register address
    input  wire logic [7:0] reg_wdata,       // Register write data
    output logic      [7:0] reg_rdata,       // Register read data
    input  wire logic       line_sync_in,    // Strap level on line sync pin
    input  wire logic       frame_sync_in,   // Strap level on frame sync pin
    output logic            line_sync_out,   // Line sync output
    output logic            line_sync_oe_n,  // Line sync enable, low drives
    output logic            frame_sync_out,  // Frame sync output
    output logic            frame_sync_oe_n, // Frame sync enable, low drives
    output logic      [7:0] video_data,      // Pixel data byte
    output logic            ready,           // Configuration window open
    output logic            busy,            // Acquisition in progress
    output logic      [1:0] strap_q          // Captured strap levels
);

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [7:0]  cfg_a_q, cfg_b_q, illum_q, presc_q, mode_q, special_q;
    logic [7:0]  emul_q;
    logic [7:0]  roi_q [6];
    logic [15:0] repeat_q, count_q;
    logic [7:0]  rep_hi_hold_q, cnt_hi_hold_q;
    logic [15:0] temp_q [4];
    logic [7:0]  rdata_q;
    tofacq_state_t st_q;
    logic [15:0] boot_q;
    logic [7:0]  lat_presc_q;
    logic [15:0] lat_count_q, lat_repeat_q;
    logic [7:0]  pre_cnt_q;
    logic [15:0] cnt_q, rep_q;
    logic [3:0]  frames_left_q;
    logic        gray_run_q, tick96;
    logic        req_tgl_q, done_tgl_q;
    logic [2:0]  done_sync_q;
    logic [2:0]  shut_sync_q;
    logic [1:0]  ls_sync_q, fs_sync_q;
    wire wr_ok      = reg_wr && (st_q != TOFACQ_ST_STRAP) && (st_q != TOFACQ_ST_COPY);
    wire trig_cmd   = wr_ok && reg_addr == ADDR_ACQ_TRIGGER && reg_wdata == TRIGGER_CODE;
    wire shut_edge  = shut_sync_q[1] && !shut_sync_q[2];
    wire start_acq  = (st_q == TOFACQ_ST_READY) && (trig_cmd || shut_edge);
    wire is_roi     = reg_addr >= ADDR_ROI_FIRST && reg_addr <= ADDR_ROI_LAST;
    wire is_temp    = reg_addr >= ADDR_TEMP_FIRST && reg_addr <= ADDR_TEMP_LAST;
    wire [2:0] roi_i  = 3'(reg_addr - ADDR_ROI_FIRST);
    wire [2:0] temp_i = 3'(reg_addr - ADDR_TEMP_FIRST);
    wire dual       = special_q == SPECIAL_DUAL;
    wire dual_phase = dual && cfg_a_q == DUALPH_CFG_A && cfg_b_q == DUALPH_CFG_B;
    wire link_done  = done_sync_q[1] != done_sync_q[2];

    // Frames per acquisition from mode; grayscale one, dual doubles, dual-phase timing always two
    logic [3:0] frames_sel;
    always_comb begin
        frames_sel = 4'd4;
        if (mode_q == MODE_GRAY || mode_q == MODE_DUAL_GRAY) begin
            frames_sel = 4'd1;
        end else if (mode_q == MODE_DIST2 || mode_q == MODE_DUAL_DIST2) begin
            frames_sel = 4'd2;
        end
        if (dual_phase) begin
            frames_sel = 4'd2;
        end else if (dual) begin
            frames_sel = 4'(frames_sel << 1);
        end
    end
    // Shutter pin synchroniser and edge detect on stages 1 and 2
    always_ff @(posedge clk) begin
        if (reset) begin
            shut_sync_q <= 3'b000;
            done_sync_q <= 3'b000;
        end else begin
            shut_sync_q <= {shut_sync_q[1:0], shutter_pin};
            done_sync_q <= {done_sync_q[1:0], done_tgl_q};
        end
    end
    // Register writes; 16-bit fields take the high byte first
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_a_q   <= RST_TIMING_CFG_A;
            cfg_b_q   <= RST_TIMING_CFG_B;
            special_q <= RST_SPECIAL_MODE;
            illum_q   <= RST_ILLUM_SELECT;
            presc_q   <= RST_INT_PRESCALER;
            mode_q    <= MODE_DIST4;
            emul_q    <= 8'h00;
            repeat_q  <= RST_REPEAT;
            count_q   <= RST_COUNT;
            rep_hi_hold_q <= 8'h00;
            cnt_hi_hold_q <= 8'h00;
            for (int i = 0; i < 6; i++) begin
                roi_q[i] <= 8'h00;
            end
        end else if (wr_ok) begin
            unique case (reg_addr)
                ADDR_TIMING_CFG_A:  cfg_a_q   <= reg_wdata;
                ADDR_TIMING_CFG_B:  cfg_b_q   <= reg_wdata;
                ADDR_SPECIAL_MODE:  special_q <= reg_wdata;
                ADDR_ILLUM_SELECT:  illum_q   <= reg_wdata;
                ADDR_INT_PRESCALER: presc_q   <= reg_wdata;
                ADDR_MEAS_MODE:     mode_q    <= reg_wdata;
                ADDR_EMULATION:     emul_q    <= reg_wdata;
                ADDR_REPEAT_HI:     rep_hi_hold_q <= reg_wdata;
                ADDR_REPEAT_LO:     repeat_q  <= {rep_hi_hold_q, reg_wdata};
                ADDR_COUNT_HI:      cnt_hi_hold_q <= reg_wdata;
                ADDR_COUNT_LO:      count_q   <= {cnt_hi_hold_q, reg_wdata};
                default: begin
                    if (is_roi) begin
                        roi_q[roi_i] <= reg_wdata;
                    end
                end
            endcase
        end
    end
    // Read mux, registered
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_TIMING_CFG_A:  rdata_q <= cfg_a_q;
                ADDR_TIMING_CFG_B:  rdata_q <= cfg_b_q;
                ADDR_SPECIAL_MODE:  rdata_q <= special_q;
                ADDR_ILLUM_SELECT:  rdata_q <= illum_q;
                ADDR_INT_PRESCALER: rdata_q <= presc_q;
                ADDR_MEAS_MODE:     rdata_q <= mode_q;
                ADDR_EMULATION:     rdata_q <= emul_q;
                ADDR_REPEAT_HI:     rdata_q <= repeat_q[15:8];
                ADDR_REPEAT_LO:     rdata_q <= repeat_q[7:0];
                ADDR_COUNT_HI:      rdata_q <= count_q[15:8];
                ADDR_COUNT_LO:      rdata_q <= count_q[7:0];
                default: begin
                    if (is_roi) begin
                        rdata_q <= roi_q[roi_i];
                    end else if (is_temp) begin
                        rdata_q <= temp_i[0] ? temp_q[temp_i[2:1]][7:0]
                                             : temp_q[temp_i[2:1]][15:8];
                    end else begin
                        rdata_q <= 8'h00;
                    end
                end
            endcase
        end
    end
    // Sequencer: boot phases, then integration, conversion, readout
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= TOFACQ_ST_STRAP;
            boot_q <= 16'h0000;
            strap_q <= 2'b11;
            lat_presc_q <= 8'h00;
            lat_count_q <= 16'h0000;
            lat_repeat_q <= 16'h0000;
            pre_cnt_q <= 8'h00;
            cnt_q <= 16'h0000;
            rep_q <= 16'h0000;
            frames_left_q <= 4'd0;
            gray_run_q <= 1'b0;
            req_tgl_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                temp_q[i] <= TEMP_DEFAULT;
            end
        end else begin
            unique case (st_q)
                TOFACQ_ST_STRAP: begin
                    boot_q <= 16'(boot_q + 16'd1);
                    if (boot_q == 16'(STRAP_CYCLES - 1)) begin
                        strap_q <= {ls_sync_q[1], fs_sync_q[1]};
                        boot_q <= 16'h0000;
                        st_q <= TOFACQ_ST_COPY;
                    end
                end
                TOFACQ_ST_COPY: begin
                    boot_q <= 16'(boot_q + 16'd1);
                    if (boot_q == 16'(EE_COPY_TIME - 1)) begin
                        st_q <= TOFACQ_ST_READY;
                    end
                end
                TOFACQ_ST_READY: begin
                    if (start_acq) begin
                        lat_presc_q <= presc_q;
                        lat_count_q <= count_q;
                        lat_repeat_q <= repeat_q;
                        pre_cnt_q <= presc_q;
                        cnt_q <= count_q;
                        rep_q <= (repeat_q == 16'h0000) ? 16'h0000 : 16'(repeat_q - 16'd1);
                        frames_left_q <= frames_sel;
                        gray_run_q <= (frames_sel == 4'd1) && !dual;
                        st_q <= TOFACQ_ST_INTEG;
                    end
                end
                TOFACQ_ST_INTEG: begin
                    // Clock at 200 MHz; ticks of 96 MHz derived by phase accumulate
                    if (tick96) begin
                        if (pre_cnt_q != 8'h00) begin
                            pre_cnt_q <= 8'(pre_cnt_q - 8'd1);
                        end else begin
                            pre_cnt_q <= lat_presc_q;
                            if (cnt_q != 16'h0000) begin
                                cnt_q <= 16'(cnt_q - 16'd1);
                            end else if (rep_q != 16'h0000) begin
                                cnt_q <= lat_count_q;
                                rep_q <= 16'(rep_q - 16'd1);
                            end else begin
                                boot_q <= 16'h0000;
                                st_q <= TOFACQ_ST_CONV;
                            end
                        end
                    end
                end
                TOFACQ_ST_CONV: begin
                    boot_q <= 16'(boot_q + 16'd1);
                    if (boot_q == 16'(CONV_CYCLES - 1)) begin
                        req_tgl_q <= !req_tgl_q;
                        st_q <= TOFACQ_ST_WAIT;
                    end
                end
                TOFACQ_ST_WAIT: begin
                    if (link_done) begin
                        frames_left_q <= 4'(frames_left_q - 4'd1);
                        if (frames_left_q == 4'd1) begin
                            if (gray_run_q) begin
                                for (int i = 0; i < 4; i++) begin
                                    temp_q[i] <= 16'(TEMP_DEFAULT + 16'(lat_count_q[3:0] + i));
                                end
                            end
                            st_q <= TOFACQ_ST_READY;
                        end else begin
                            pre_cnt_q <= lat_presc_q;
                            cnt_q <= lat_count_q;
                            rep_q <= (lat_repeat_q == 16'h0000) ? 16'h0000
                                                                 : 16'(lat_repeat_q - 16'd1);
                            st_q <= TOFACQ_ST_INTEG;
                        end
                    end
                end
                default: st_q <= TOFACQ_ST_READY;
            endcase
        end
    end

    // ****************************************
    // 96 MHz tick and strap synchronisers
    // ****************************************
    logic [7:0] acc_q;
    wire  [8:0] acc_sum = {1'b0, acc_q} + 9'(INT_TICK_MHZ);
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_q <= 8'h00;
            tick96 <= 1'b0;
            ls_sync_q <= 2'b11;
            fs_sync_q <= 2'b11;
        end else begin
            tick96 <= acc_sum >= 9'(CLK_MHZ);
            acc_q <= (acc_sum >= 9'(CLK_MHZ)) ? 8'(acc_sum - 9'(CLK_MHZ)) : acc_sum[7:0];
            ls_sync_q <= {ls_sync_q[0], line_sync_in};
            fs_sync_q <= {fs_sync_q[0], frame_sync_in};
        end
    end
    // Status outputs, registered
    always_ff @(posedge clk) begin
        if (reset) begin
            ready <= 1'b0;
            busy <= 1'b0;
        end else begin
            ready <= st_q == TOFACQ_ST_READY;
            busy <= st_q == TOFACQ_ST_INTEG || st_q == TOFACQ_ST_CONV || st_q == TOFACQ_ST_WAIT;
        end
    end
    assign reg_rdata = rdata_q;

    // ****************************************
    // Link domain: frame readout on pixel_clock
    // ****************************************
    // ROI bounds are quasi-static during a frame; sampled once per frame start
    logic [2:0]   lreq_sync_q;
    logic         lreset_q;
    logic [1:0]   lrst_sync_q;
    tofacq_link_t lk_q;
    logic [8:0]   col_q, row_q, col_end_q, row_end_q, col_beg_q;
    logic         hs_q, vs_q, drive_q;
    logic [7:0]   pix_q;
    wire          lreq = lreq_sync_q[1] != lreq_sync_q[2];
    wire  [8:0]   roi_x0 = {roi_q[0][0], roi_q[1]};
    wire  [8:0]   roi_x1 = {roi_q[2][0], roi_q[3]};
    wire  [8:0]   roi_x1_eff = (roi_x1 == 9'd0) ? 9'(COLS - 1) : roi_x1;
    wire  [8:0]   roi_y1_eff = (roi_q[5] == 8'h00) ? 9'(ROWS / 2 - 1) : {1'b0, roi_q[5]};
    always_ff @(posedge pixel_clock) begin
        lrst_sync_q <= {lrst_sync_q[0], reset};
        lreset_q <= lrst_sync_q[1];
    end
    // Sync pins stay released until the first frame so strap pull-ups read true
    always_ff @(posedge pixel_clock) begin
        if (lreset_q) begin
            lreq_sync_q <= 3'b000;
            done_tgl_q <= 1'b0;
            lk_q <= TOFACQ_LK_IDLE;
            col_q <= 9'd0;
            row_q <= 9'd0;
            col_beg_q <= 9'd0;
            col_end_q <= 9'd0;
            row_end_q <= 9'd0;
            hs_q <= 1'b0;
            vs_q <= 1'b0;
            drive_q <= 1'b0;
            pix_q <= 8'h00;
        end else begin
            lreq_sync_q <= {lreq_sync_q[1:0], req_tgl_q};
            drive_q <= drive_q || lreq;
            unique case (lk_q)
                TOFACQ_LK_IDLE: begin
                    hs_q <= 1'b0;
                    vs_q <= 1'b0;
                    if (lreq) begin
                        col_beg_q <= roi_x0;
                        col_q <= roi_x0;
                        col_end_q <= roi_x1_eff;
                        row_q <= {1'b0, roi_q[4]};
                        row_end_q <= roi_y1_eff;
                        vs_q <= 1'b1;
                        hs_q <= 1'b1;
                        lk_q <= TOFACQ_LK_ROW;
                    end
                end
                TOFACQ_LK_ROW: begin
                    pix_q <= col_q[7:0] ^ row_q[7:0];
                    col_q <= 9'(col_q + 9'd1);
                    if (col_q == col_end_q) begin
                        hs_q <= 1'b0;
                        lk_q <= TOFACQ_LK_GAP;
                    end
                end
                TOFACQ_LK_GAP: begin
                    vs_q <= 1'b0;
                    if (row_q >= row_end_q) begin
                        done_tgl_q <= !done_tgl_q;
                        lk_q <= TOFACQ_LK_IDLE;
                    end else begin
                        row_q <= 9'(row_q + 9'd1);
                        col_q <= col_beg_q;
                        hs_q <= 1'b1;
                        lk_q <= TOFACQ_LK_ROW;
                    end
                end
                default: lk_q <= TOFACQ_LK_IDLE;
            endcase
        end
    end

    assign line_sync_out   = hs_q;
    assign frame_sync_out  = vs_q;
    assign line_sync_oe_n  = !drive_q;
    assign frame_sync_oe_n = !drive_q;
    assign video_data      = pix_q;

endmodule

// file: tb/tofacq_chk.sv
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module tofacq_chk
    import tofacq_pkg::*;
(
    input wire logic       clk,            // System clock
    input wire logic       reset,          // Sync reset
    input wire logic       pixel_clock,    // Link clock
    input wire logic       shutter_pin,    // Shutter input
    input wire logic       reg_wr,         // Write strobe
    input wire logic       reg_rd,         // Read strobe
    input wire logic [7:0] reg_addr,       // Address
    input wire logic [7:0] reg_wdata,      // Write data
    input wire logic [7:0] reg_rdata,      // Read data
    input wire logic       line_sync_out,  // Line sync
    input wire logic       line_sync_oe_n, // Line sync enable
    input wire logic       frame_sync_out, // Frame sync
    input wire logic       ready,          // Window open
    input wire logic       busy            // Acquiring
);
    // Software trigger decode
    wire trig = reg_wr && reg_addr == ADDR_ACQ_TRIGGER && reg_wdata == TRIGGER_CODE;

    chk_mode_readback: assert property (@(posedge clk) disable iff (reset)
        ready && reg_wr && reg_addr == ADDR_MEAS_MODE ##2 reg_rd && reg_addr == ADDR_MEAS_MODE
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("mode readback wrong");
    chk_trigger_busy: assert property (@(posedge clk) disable iff (reset)
        ready && trig |-> ##2 busy) else $error("trigger did not start");
    chk_ready_busy: assert property (@(posedge clk) disable iff (reset)
        !(ready && busy)) else $error("ready while busy");
    chk_boot_closed: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> !ready [*8]) else $error("window opened early");
    chk_busy_holds: assert property (@(posedge clk) disable iff (reset)
        $rose(busy) |-> busy [*8]) else $error("cycle cut short");
    chk_no_restart: assert property (@(posedge clk) disable iff (reset)
        busy && $rose(shutter_pin) |-> busy [*4]) else $error("shutter disturbed cycle");
    chk_frame_start: assert property (@(posedge pixel_clock) disable iff (reset)
        $rose(frame_sync_out) |-> $rose(line_sync_out)) else $error("syncs not together");
    chk_first_row: assert property (@(posedge pixel_clock) disable iff (reset)
        $fell(line_sync_out) |=> !frame_sync_out) else $error("frame sync too long");
    chk_sync_driven: assert property (@(posedge pixel_clock) disable iff (reset)
        line_sync_out |-> !line_sync_oe_n) else $error("sync high undriven");
endmodule
bind tofacq_top tofacq_chk chk_u (.clk(clk), .reset(reset), .pixel_clock(pixel_clock),
    .shutter_pin(shutter_pin), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_sync_out(line_sync_out),
    .line_sync_oe_n(line_sync_oe_n), .frame_sync_out(frame_sync_out), .ready(ready),
    .busy(busy));

// file: tb/tofacq_host_rx.sv
`timescale 1ns/1ps
// Host receiver: frame, row and pixel counters
module tofacq_host_rx (
    input  wire logic       pixel_clock,     // Link clock
    input  wire logic       line_sync_out,   // Line sync
    input  wire logic       line_sync_oe_n,  // Line enable
    input  wire logic       frame_sync_out,  // Frame sync
    input  wire logic       frame_sync_oe_n, // Frame enable
    output logic            line_sync_in,    // Line pin level
    output logic            frame_sync_in,   // Frame pin level
    output logic      [7:0] frames,          // Frames seen
    output logic      [7:0] rows,            // Rows in frame
    output logic      [7:0] pix              // Pixels in last row
);
    logic       hs_q = 1'b0;
    logic       vs_q = 1'b0;
    logic [7:0] pc   = 8'h00;
    // Pull-ups win whenever the device lets go
    assign line_sync_in  = line_sync_oe_n ? 1'b1 : line_sync_out;
    assign frame_sync_in = frame_sync_oe_n ? 1'b1 : frame_sync_out;
    initial begin
        frames = 8'h00;
        rows = 8'h00;
        pix = 8'h00;
    end
    // Active-high syncs to match the reset polarity
    always @(posedge pixel_clock) begin
        hs_q <= line_sync_out;
        vs_q <= frame_sync_out;
        if (frame_sync_out && !vs_q) frames <= frames + 8'h01;
        if (line_sync_out && !hs_q) begin
            rows <= (frame_sync_out && !vs_q) ? 8'h01 : rows + 8'h01;
            pc <= 8'h01;
        end else if (line_sync_out) pc <= pc + 8'h01;
        if (!line_sync_out && hs_q) pix <= pc;
    end
endmodule

// file: tb/tofacq_tb_top.sv
`timescale 1ns/1ps
module tofacq_tb_top
    import tofacq_pkg::*;
();
    logic clk = 0, reset = 1, pixel_clock = 0, shutter_pin = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, frames, rows, pix, f0, vd;
    logic       lsi, fsi, ls, ls_n, fs, fs_n, ready, busy;
    logic [1:0] strap_q;
    int err_count = 0, checked = 0;
    // Defaults, then writes read back {address, data}
    logic [15:0] dflt[13] = '{16'h2230, 16'h2535, 16'h3c26, 16'h8500, 16'h9234, 16'h9400,
        16'ha000, 16'ha101, 16'ha212, 16'ha3bf, 16'h6020, 16'h1000, 16'ha600};
    // Count low byte first: a lone high write leaves the live count unchanged
    logic [15:0] wtab[23] = '{16'h9480, 16'h2234, 16'h253e, 16'h923c, 16'h921c, 16'h92cc,
        16'h3c16, 16'h3c06, 16'h3c26, 16'h9400, 16'h2230, 16'h2535, 16'ha000, 16'ha101,
        16'ha303, 16'ha200, 16'ha655, 16'h9600, 16'h9702, 16'h9800, 16'h9905, 16'h9a01, 16'h9b02};
    always #2.5 clk = ~clk;
    initial begin
        #13;
        forever #40 pixel_clock = ~pixel_clock;
    end
    // Shortened boot and conversion keep the run brief
    tofacq_top #(.EE_COPY_TIME(16), .CONV_CYCLES(4)) dut_u (.clk(clk), .reset(reset),
        .pixel_clock(pixel_clock), .shutter_pin(shutter_pin), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .line_sync_in(lsi), .frame_sync_in(fsi), .line_sync_out(ls), .line_sync_oe_n(ls_n),
        .frame_sync_out(fs), .frame_sync_oe_n(fs_n), .video_data(vd), .ready(ready),
        .busy(busy), .strap_q(strap_q));
    tofacq_host_rx host_u (.pixel_clock(pixel_clock), .line_sync_out(ls),
        .line_sync_oe_n(ls_n), .frame_sync_out(fs), .frame_sync_oe_n(fs_n),
        .line_sync_in(lsi), .frame_sync_in(fsi), .frames(frames), .rows(rows), .pix(pix));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk) #1;
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) #1;
        reg_rd = 1;
        reg_addr = a;
        @(posedge clk) #1;
        reg_rd = 0;
        check(reg_rdata, exp);
    endtask
    // Wait bounded for a level on ready or busy
    task automatic wait_for(input logic want_ready, input int lim);
        for (int i = 0; i < lim && (want_ready ? ready !== 1'b1 : busy !== 1'b0); i++)
            @(posedge clk) #1;
        if (want_ready ? ready !== 1'b1 : busy !== 1'b0) begin
            err_count++;
            $display("ERROR %0t: wait limit", $time);
        end
    endtask
    // One acquisition; with the pin a second edge lands mid-cycle
    task automatic acq(input logic [7:0] m, input logic [7:0] s, input logic [7:0] n, bit pin);
        wr(ADDR_MEAS_MODE, m);
        wr(ADDR_SPECIAL_MODE, s);
        f0 = frames;
        if (pin) shutter_pin = 1;
        else wr(ADDR_ACQ_TRIGGER, TRIGGER_CODE);
        for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk) #1;
        check({7'h0, busy}, 8'h01);
        shutter_pin = 0;
        repeat (4) @(posedge clk) #1;
        shutter_pin = pin;
        repeat (4) @(posedge clk) #1;
        shutter_pin = 0;
        wait_for(0, 4000);
        wait_for(1, 4000);
        repeat (400) @(posedge clk) #1;
        check(8'(frames - f0), n);
        check(rows, 8'h02);
        check(pix, 8'h04);
        check(vd, 8'h07);
        $display("acquisition mode %h done", m);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000; // Several times the expected run
        err_count++;
        $display("ERROR %0t: timeout", $time);
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge clk) #1;
        reset = 0;
        wr(ADDR_MEAS_MODE, MODE_DIST2);
        wait_for(1, 2000);
        check({6'h0, strap_q}, 8'h03);
        foreach (dflt[i]) rd(dflt[i][15:8], dflt[i][7:0]);
        foreach (wtab[i]) begin
            wr(wtab[i][15:8], wtab[i][7:0]);
            rd(wtab[i][15:8], wtab[i][7:0]);
        end
        $display("register test done");
        acq(MODE_DIST4, RST_SPECIAL_MODE, 8'h04, 0);
        acq(MODE_DIST2, RST_SPECIAL_MODE, 8'h02, 0);
        acq(MODE_GRAY, RST_SPECIAL_MODE, 8'h01, 1);
        rd(ADDR_TEMP_FIRST, 8'h20);
        rd(ADDR_TEMP_FIRST + 8'h01, 8'h03);
        acq(MODE_DUAL_DIST2, SPECIAL_DUAL, 8'h04, 0);
        wr(ADDR_TIMING_CFG_A, DUALPH_CFG_A);
        wr(ADDR_TIMING_CFG_B, DUALPH_CFG_B);
        acq(MODE_DIST2, SPECIAL_DUAL, 8'h02, 0);
        tally_and_finish;
    end
endmodule
